// >>> dv/tb_wireless_rx_link_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_wireless_rx_link_control;
    import wrlc_pkg::*;
    localparam logic [63:0] SEQ = {14'h0, HDR_SIGSTR, SIGSTR_RST, 1'b0,
        HDR_IDENT, 8'h5A, 1'b0, HDR_CONFIG, 8'h0F};
    localparam logic [63:0] SEQ_M = {13'h0, {51{1'b1}}};
    logic          i_ref_clk, i_reset, i_en_n, i_eoc, i_die_hot, i_rect_ok;
    logic          i_remote_temp_a, i_remote_temp_b, field_on, err, o_irq;
    logic          o_coil_term_a_mod, o_coil_term_b_mod, o_fault_n_o;
    logic          o_fault_n_oe, o_link_active_n_o, o_link_active_n_oe;
    logic          o_out_hiz;
    logic [31:0]   rd;
    logic [63:0]   bits;
    wrlc_apb_req_t i_apb;
    wrlc_apb_rsp_t o_apb;
    int            mismatches, checked;

    wrlc_top #(.BIT_CYCLES(8)) uut (.i_ref_clk, .i_reset, .i_apb, .o_apb,
        .i_en_n, .i_eoc, .i_rect_ok, .i_die_hot, .i_remote_temp_a,
        .i_remote_temp_b, .o_coil_term_a_mod, .o_coil_term_b_mod, .o_fault_n_o,
        .o_fault_n_oe, .o_link_active_n_o, .o_link_active_n_oe, .o_out_hiz,
        .o_irq);
    wrlc_tx_model #(.BIT_CYCLES(8)) tx (.i_ref_clk, .i_reset,
        .i_field_on(field_on), .i_mod_a(o_coil_term_a_mod),
        .i_mod_b(o_coil_term_b_mod), .o_rect_ok(i_rect_ok), .o_bits(bits));

    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    task chk32(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task chk1(input logic g, input logic x);
        chk32({31'h0, g}, {31'h0, x});
    endtask
    task conclude;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_ref_clk);
        i_apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_ref_clk);
        i_apb.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_ref_clk);
            k++;
        end while (o_apb.pready !== 1'b1 && k < 20);
        rd = o_apb.prdata;
        err = o_apb.pslverr;
        i_apb <= '0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] x, input logic e);
        apb(1'b0, a, 32'h0);
        chk32(rd, x);
        chk1(err, e);
    endtask
    task wait_pat(input logic [63:0] p, input logic [63:0] m);
        int k;
        k = 0;
        while ((bits & m) !== p && k < 3000) begin
            @(posedge i_ref_clk);
            k++;
        end
        chk1(k < 3000, 1'b1);
        repeat (24) @(posedge i_ref_clk);
    endtask
    task t_start;
        rdchk(OFS_CTRL, {16'h0, CTRL_STEP_RST, 6'h0, CTRL_CMD_RST}, 1'b0);
        rdchk(OFS_SIGSTR, {24'h0, SIGSTR_RST}, 1'b0);
        rdchk(8'h20, 32'h0, 1'b1);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        field_on <= 1'b1;
        wait_pat(SEQ, SEQ_M);
        chk1(o_link_active_n_oe, 1'b1);
        chk1(o_irq, 1'b1);
        rdchk(OFS_IRQ_STAT, 32'h1, 1'b0);
        @(posedge i_ref_clk);
        chk1(o_irq, 1'b0);
    endtask
    task t_cmds;
        wrlc_cmd_t  c [4];
        logic [7:0] d [4];
        c = '{CMD_RAISE, CMD_LOWER, CMD_HOLD, CMD_STOP};
        d = '{8'h10, 8'hF0, 8'h00, EPT_SWSTOP};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_CTRL, {16'h0, 8'h10, 6'h0, c[i]});
            wait_pat({48'h0, (i < 3) ? HDR_CTLERR : HDR_ENDPT, d[i]},
                64'hFFFF);
        end
        chk1(o_out_hiz, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h0);
        wait_pat(SEQ, SEQ_M);
    endtask
    task t_eoc;
        rdchk(OFS_IRQ_STAT, 32'h3, 1'b0);
        i_eoc <= 1'b1;
        wait_pat({48'h0, HDR_ENDPT, EPT_CHARGE}, 64'hFFFF);
        chk1(o_out_hiz, 1'b1);
        chk1(o_fault_n_oe, 1'b1);
        chk1(o_irq, 1'b0);
        rdchk(OFS_IRQ_STAT, 32'h6, 1'b0);
        i_eoc <= 1'b0;
        wait_pat(SEQ, SEQ_M);
    endtask
    task t_faults;
        for (int i = 0; i < 5; i++) begin
            {i_en_n, i_eoc, i_die_hot, i_remote_temp_a, i_remote_temp_b}
                <= 5'h01 << i;
            repeat (3) @(posedge i_ref_clk);
            chk1(o_fault_n_oe, 1'b1);
            chk1(o_out_hiz, i == 4);
            {i_en_n, i_eoc, i_die_hot, i_remote_temp_a, i_remote_temp_b}
                <= 5'h00;
            repeat (2) @(posedge i_ref_clk);
            chk1(o_fault_n_oe, 1'b0);
        end
    endtask
    initial begin
        {i_en_n, i_eoc, i_die_hot, i_remote_temp_a, i_remote_temp_b} = 5'h00;
        {i_apb, field_on, mismatches, checked} = '0;
        i_reset = 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        t_start;
        t_cmds;
        t_eoc;
        t_faults;
        conclude;
    end
    initial begin
        #(20 * 40000);
        mismatches++;
        conclude;
    end
endmodule
`default_nettype wire

// >>> dv/wrlc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module wrlc_properties
    import wrlc_pkg::*;
#(
    parameter int BIT_CYCLES = 8
) (
    input wire logic                    i_ref_clk,
    input wire logic                    i_reset,
    input wire wrlc_pkg::wrlc_apb_req_t i_apb,
    input wire wrlc_pkg::wrlc_apb_rsp_t o_apb,
    input wire logic                    i_en_n,
    input wire logic                    i_eoc,
    input wire logic                    i_die_hot,
    input wire logic                    i_remote_temp_a,
    input wire logic                    i_remote_temp_b,
    input wire logic                    o_coil_term_a_mod,
    input wire logic                    o_coil_term_b_mod,
    input wire logic                    o_fault_n_oe,
    input wire logic                    o_link_active_n_o,
    input wire logic                    o_link_active_n_oe,
    input wire logic                    o_out_hiz
);
    localparam int HIZ_MAX = 24 * BIT_CYCLES;
    wire logic any_fault;
    assign any_fault = i_en_n | i_eoc | i_die_hot | i_remote_temp_a
        | i_remote_temp_b;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    AST_FAULT_SET: assert property (any_fault |=> o_fault_n_oe)
        else $error("fault flag not pulled low");
    AST_FAULT_REL: assert property (!any_fault |=> !o_fault_n_oe)
        else $error("fault flag not released");
    AST_MOD_PAIR: assert property (
        o_coil_term_a_mod == o_coil_term_b_mod)
        else $error("coil terminals switched apart");
    AST_EN_OFF: assert property (
        i_en_n |-> ##2 (!o_coil_term_a_mod && !o_link_active_n_oe && o_out_hiz))
        else $error("enable high did not shut down");
    AST_BIT_HOLD: assert property (
        $changed(o_coil_term_a_mod) && !i_en_n
        |=> ($stable(o_coil_term_a_mod) || i_en_n) [*7])
        else $error("bit period too short");
    AST_EOC_HIZ: assert property (
        $fell(o_link_active_n_oe) && i_eoc |-> ##[1:HIZ_MAX] o_out_hiz)
        else $error("output not high impedance after end of charge");
    AST_ACT_OUT: assert property (
        o_link_active_n_oe |-> !o_link_active_n_o && !o_out_hiz)
        else $error("activity pin driven outside power transfer");
    AST_APB_WAIT: assert property (i_apb.psel && i_apb.penable
        && !$past(i_apb.penable) |=> o_apb.pready)
        else $error("ready not after one wait state");
    AST_APB_PULSE: assert property (o_apb.pready |=> !o_apb.pready)
        else $error("ready held too long");
endmodule
bind wrlc_top wrlc_properties #(.BIT_CYCLES(BIT_CYCLES)) props (.i_ref_clk,
    .i_reset, .i_apb, .o_apb, .i_en_n, .i_eoc, .i_die_hot, .i_remote_temp_a,
    .i_remote_temp_b, .o_coil_term_a_mod, .o_coil_term_b_mod, .o_fault_n_oe,
    .o_link_active_n_o, .o_link_active_n_oe, .o_out_hiz);
`default_nettype wire

// >>> dv/wrlc_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module wrlc_tx_model #(
    parameter int BIT_CYCLES = 8
) (
    input  wire logic  i_ref_clk,
    input  wire logic  i_reset,
    input  wire logic  i_field_on,
    input  wire logic  i_mod_a,
    input  wire logic  i_mod_b,
    output logic        o_rect_ok,
    output logic [63:0] o_bits
);
    int cnt;
    always_ff @(posedge i_ref_clk) begin
        o_rect_ok <= i_field_on;
        if (i_reset) begin
            cnt <= 0;
            o_bits <= '0;
        end else begin
            cnt <= (cnt == BIT_CYCLES - 1) ? 0 : cnt + 1;
            // load change seen only when both terminals ground
            if (cnt == BIT_CYCLES / 2) begin
                o_bits <= {o_bits[62:0], i_mod_a & i_mod_b};
            end
        end
    end
endmodule
`default_nettype wire

// >>> inc/wrlc_pkg.sv
`default_nettype none
package wrlc_pkg;
    // timing: 2 kbit/s link, 50 MHz core clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int BIT_RATE_BPS  = 2000;
    localparam int BIT_PERIOD_NS = 1000000000 / BIT_RATE_BPS;
    localparam int BIT_CYC       = BIT_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PKT_BITS      = 16;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_SIGSTR   = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    // reset values
    localparam logic [1:0] CTRL_CMD_RST  = 2'h0;
    localparam logic [7:0] CTRL_STEP_RST = 8'h04;
    localparam logic [7:0] SIGSTR_RST    = 8'h80;
    localparam logic [3:0] IRQ_MASK_RST  = 4'h0;

    // field positions
    localparam int CTRL_CMD_LSB  = 0;
    localparam int CTRL_STEP_LSB = 8;
    localparam int STAT_ST_LSB   = 0;
    localparam int STAT_FLT_LSB  = 4;
    localparam int STAT_BUSY_BIT = 8;

    // irq status bits
    localparam int IRQ_LINK_UP = 0;
    localparam int IRQ_EPT     = 1;
    localparam int IRQ_FAULT   = 2;
    localparam int IRQ_SHDN    = 3;

    // packet headers and end-of-transfer reasons
    localparam logic [7:0] HDR_SIGSTR = 8'h11;
    localparam logic [7:0] HDR_IDENT  = 8'h21;
    localparam logic [7:0] HDR_CONFIG = 8'h31;
    localparam logic [7:0] HDR_CTLERR = 8'h41;
    localparam logic [7:0] HDR_ENDPT  = 8'h51;
    localparam logic [7:0] EPT_CHARGE = 8'h01;
    localparam logic [7:0] EPT_SWSTOP = 8'h00;

    typedef enum logic [1:0] {
        CMD_HOLD  = 2'b00,
        CMD_RAISE = 2'b01,
        CMD_LOWER = 2'b10,
        CMD_STOP  = 2'b11
    } wrlc_cmd_t;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b000,
        ST_SIG  = 3'b001,
        ST_ID   = 3'b010,
        ST_CFG  = 3'b011,
        ST_XFER = 3'b100,
        ST_EPT  = 3'b101,
        ST_SHUT = 3'b110
    } wrlc_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } wrlc_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } wrlc_apb_rsp_t;

    typedef struct packed {
        wrlc_state_t   state;
        logic [15:0]   bit_cnt;
        logic [15:0]   shreg;
        logic [4:0]    nbits;
        logic          busy;
        logic          mod;
        logic          fault_oe;
        logic          fault_q;
        logic          act_oe;
        logic          out_hiz;
        wrlc_cmd_t     cmd;
        logic [7:0]    step;
        logic [7:0]    sigstr;
        logic [3:0]    irq_stat;
        logic [3:0]    irq_mask;
        logic          irq;
        wrlc_apb_rsp_t apb;
    } wrlc_regs_t;
endpackage
`default_nettype wire

// >>> src/wrlc_top.sv
`timescale 1ns/1ps
`default_nettype none
module wrlc_top
    import wrlc_pkg::*;
#(
    parameter int       BIT_CYCLES = wrlc_pkg::BIT_CYC,
    parameter bit [7:0] ID_DATA    = 8'h5A, // arbitrary value
    parameter bit [7:0] CFG_DATA   = 8'h0F
) (
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_reset,
    input  wire wrlc_pkg::wrlc_apb_req_t i_apb,
    output var  wrlc_pkg::wrlc_apb_rsp_t o_apb,
    input  wire logic                    i_en_n,
    input  wire logic                    i_eoc,
    input  wire logic                    i_rect_ok,
    input  wire logic                    i_die_hot,
    input  wire logic                    i_remote_temp_a,
    input  wire logic                    i_remote_temp_b,
    output logic                         o_coil_term_a_mod,
    output logic                         o_coil_term_b_mod,
    output logic                         o_fault_n_o,
    output logic                         o_fault_n_oe,
    output logic                         o_link_active_n_o,
    output logic                         o_link_active_n_oe,
    output logic                         o_out_hiz,
    output logic                         o_irq
);
    import wrlc_pkg::*;

    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [4:0]  NBITS    = 5'(PKT_BITS);

    wrlc_regs_t  r_reg;
    wrlc_regs_t  r_next;
    logic        tick;
    logic        pkt_done;
    logic        fault_now;
    logic        ept_req;
    logic        acc;
    logic        rd_clr;
    logic [3:0]  ev;
    logic [7:0]  cep_data;
    logic [31:0] rdata;
    logic        hit;

    task automatic launch(input logic [7:0] hdr, input logic [7:0] dat);
        r_next.shreg = {hdr, dat};
        r_next.nbits = NBITS;
        r_next.busy  = 1'b1;
    endtask

    always_comb begin
        r_next    = r_reg;
        ev        = 4'h0;
        rd_clr    = 1'b0;
        rdata     = 32'h0;
        hit       = 1'b1;
        pkt_done  = 1'b0;
        tick      = (r_reg.bit_cnt == BIT_LAST);
        fault_now = i_en_n | i_eoc | i_die_hot
                  | i_remote_temp_a | i_remote_temp_b;
        ept_req   = i_eoc | (r_reg.cmd == CMD_STOP);
        unique case (r_reg.cmd)
            CMD_RAISE: cep_data = r_reg.step;
            CMD_LOWER: cep_data = 8'(-r_reg.step);
            CMD_HOLD:  cep_data = 8'h00;
            CMD_STOP:  cep_data = 8'h00;
        endcase

        // bit timer and serialiser
        r_next.bit_cnt = tick ? 16'h0 : r_reg.bit_cnt + 16'h1;
        if (tick && r_reg.busy) begin
            if (r_reg.nbits != 5'h0) begin
                r_next.mod   = r_reg.shreg[15];
                r_next.shreg = {r_reg.shreg[14:0], 1'b0};
                r_next.nbits = r_reg.nbits - 5'h1;
            end else begin
                r_next.mod  = 1'b0;
                r_next.busy = 1'b0;
                pkt_done    = 1'b1;
            end
        end

        // link sequencer
        unique case (r_reg.state)
            ST_OFF: begin
                if (i_rect_ok && !i_en_n) begin
                    if (i_eoc) begin
                        r_next.state = ST_SHUT;
                    end else begin
                        launch(HDR_SIGSTR, r_reg.sigstr);
                        r_next.state = ST_SIG;
                    end
                end
            end
            ST_SIG, ST_ID, ST_CFG, ST_XFER: begin
                if (pkt_done) begin
                    if (ept_req) begin
                        launch(HDR_ENDPT, i_eoc ? EPT_CHARGE
                                                : EPT_SWSTOP);
                        r_next.state = ST_EPT;
                    end else if (r_reg.state == ST_SIG) begin
                        launch(HDR_IDENT, ID_DATA);
                        r_next.state = ST_ID;
                    end else if (r_reg.state == ST_ID) begin
                        launch(HDR_CONFIG, CFG_DATA);
                        r_next.state = ST_CFG;
                    end else begin
                        if (r_reg.state == ST_CFG) begin
                            ev[IRQ_LINK_UP] = 1'b1;
                        end
                        launch(HDR_CTLERR, cep_data);
                        r_next.state = ST_XFER;
                    end
                end
            end
            ST_EPT: begin
                if (pkt_done) begin
                    ev[IRQ_EPT]  = 1'b1;
                    r_next.state = ST_SHUT;
                end
            end
            ST_SHUT: begin
                if (!ept_req) begin
                    r_next.state = ST_OFF;
                end
            end
            default: r_next.state = ST_OFF;
        endcase

        // loss of power or enable high aborts everything
        if (i_en_n || !i_rect_ok) begin
            if (r_reg.state != ST_OFF && i_en_n) begin
                ev[IRQ_SHDN] = 1'b1;
            end
            r_next.state = ST_OFF;
            r_next.busy  = 1'b0;
            r_next.mod   = 1'b0;
        end

        r_next.act_oe   = (r_next.state == ST_XFER);
        r_next.out_hiz  = (r_next.state != ST_XFER)
                        && (r_next.state != ST_EPT);
        r_next.fault_oe = fault_now;
        r_next.fault_q  = fault_now;
        if (fault_now && !r_reg.fault_q) begin
            ev[IRQ_FAULT] = 1'b1;
        end

        // apb slave, one wait state
        acc = i_apb.psel && i_apb.penable;
        unique case (i_apb.paddr)
            OFS_CTRL: begin
                rdata[CTRL_CMD_LSB +: 2]  = r_reg.cmd;
                rdata[CTRL_STEP_LSB +: 8] = r_reg.step;
            end
            OFS_SIGSTR:   rdata[7:0] = r_reg.sigstr;
            OFS_STATUS: begin
                rdata[STAT_ST_LSB +: 3]  = r_reg.state;
                rdata[STAT_FLT_LSB]      = r_reg.fault_oe;
                rdata[STAT_BUSY_BIT]     = r_reg.busy;
            end
            OFS_IRQ_STAT: rdata[3:0] = r_reg.irq_stat;
            OFS_IRQ_MASK: rdata[3:0] = r_reg.irq_mask;
            default:      hit = 1'b0;
        endcase
        r_next.apb.pready = acc && !r_reg.apb.pready;
        if (acc && !r_reg.apb.pready) begin
            r_next.apb.pslverr = !hit;
            r_next.apb.prdata  = i_apb.pwrite ? 32'h0 : rdata;
        end else begin
            r_next.apb.pslverr = 1'b0;
            r_next.apb.prdata  = 32'h0;
        end
        if (acc && r_reg.apb.pready) begin
            if (i_apb.pwrite) begin
                unique case (i_apb.paddr)
                    OFS_CTRL: begin
                        r_next.cmd  = wrlc_cmd_t'(
                            i_apb.pwdata[CTRL_CMD_LSB +: 2]);
                        r_next.step = i_apb.pwdata[CTRL_STEP_LSB +: 8];
                    end
                    OFS_SIGSTR:   r_next.sigstr   = i_apb.pwdata[7:0];
                    OFS_IRQ_MASK: r_next.irq_mask = i_apb.pwdata[3:0];
                    default:      r_next.sigstr   = r_reg.sigstr;
                endcase
            end else if (i_apb.paddr == OFS_IRQ_STAT) begin
                rd_clr = 1'b1;
            end
        end

        // sticky events, set beats read-clear
        r_next.irq_stat = (rd_clr ? 4'h0 : r_reg.irq_stat) | ev;
        r_next.irq      = |(r_next.irq_stat & r_next.irq_mask);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            r_reg          <= '0;
            r_reg.state    <= ST_OFF;
            r_reg.out_hiz  <= 1'b1;
            r_reg.cmd      <= wrlc_cmd_t'(CTRL_CMD_RST);
            r_reg.step     <= CTRL_STEP_RST;
            r_reg.sigstr   <= SIGSTR_RST;
            r_reg.irq_mask <= IRQ_MASK_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_apb              = r_reg.apb;
    assign o_coil_term_a_mod  = r_reg.mod;
    assign o_coil_term_b_mod  = r_reg.mod;
    assign o_fault_n_o        = 1'b0;
    assign o_fault_n_oe       = r_reg.fault_oe;
    assign o_link_active_n_o  = 1'b0;
    assign o_link_active_n_oe = r_reg.act_oe;
    assign o_out_hiz          = r_reg.out_hiz;
    assign o_irq              = r_reg.irq;
endmodule
`default_nettype wire
